// >>> design/bridge_channel.v
`timescale 1ns/10ps
`include "hb_pwm_map.vh"
module bridge_channel #(
  parameter CW = 8
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          pwm,
  input  wire [1:0]    bridge_drive_mode,
  input  wire          bridge_pwm_follow_enable,
  input  wire          active_freewheel_sel,
  input  wire          split_precharge_enable,
  input  wire          active_fw_detect_enable,
  input  wire          detected_high_active,
  input  wire [CW-1:0] freewheel_crossconduction_time,
  input  wire [CW-1:0] active_crossconduction_time,
  input  wire [CW-1:0] active_blank_time,
  input  wire [CW-1:0] precharge_phase_time,
  input  wire [CW-1:0] precharge_split_time,
  input  wire [5:0]    precharge_current_a,
  input  wire [5:0]    precharge_current_b,
  input  wire [5:0]    max_drive_current_setting,
  input  wire          rise_done,
  input  wire          fall_done,
  output reg           high_side_gate,
  output reg           low_side_gate,
  output reg           active_discharge,
  output reg  [1:0]    phase,
  output reg  [5:0]    phase_current,
  output reg           active_is_high,
  output reg  [31:0]   measured_switch_times
);
  reg [CW-1:0] on_cnt_q;
  reg [CW-1:0] off_cnt_q;
  reg [CW-1:0] ph_cnt_q;
  reg [CW-1:0] rise_cnt_q;
  reg [CW-1:0] fall_cnt_q;
  reg          pwm_q;
  reg          short_q;
  reg          rise_run_q;
  reg          fall_run_q;
  wire         follow;
  wire         rise_edge;
  wire         fall_edge;
  wire [5:0]   cur_sel;

  function [5:0] clamp;
    input [5:0] v;
    input [5:0] m;
    begin
      clamp = (v > m) ? m : v;
    end
  endfunction

  function [CW-1:0] inc;
    input [CW-1:0] v;
    begin
      inc = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  assign follow = bridge_pwm_follow_enable &&
                  (bridge_drive_mode == `MODE_LOW_PWM || bridge_drive_mode == `MODE_HIGH_PWM);
  assign rise_edge = pwm & ~pwm_q;
  assign fall_edge = ~pwm & pwm_q;
  assign cur_sel = (split_precharge_enable && ph_cnt_q >= precharge_split_time) ?
                   precharge_current_b : precharge_current_a;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_side_gate        <= 1'b0;
      low_side_gate         <= 1'b0;
      active_discharge      <= 1'b0;
      phase                 <= `PHASE_NONE;
      phase_current         <= 6'h00;
      active_is_high        <= 1'b0;
      measured_switch_times <= `RST_TIMES;
      on_cnt_q              <= {CW{1'b0}};
      off_cnt_q             <= {CW{1'b0}};
      ph_cnt_q              <= {CW{1'b0}};
      rise_cnt_q            <= {CW{1'b0}};
      fall_cnt_q            <= {CW{1'b0}};
      pwm_q                 <= 1'b0;
      short_q               <= 1'b0;
      rise_run_q            <= 1'b0;
      fall_run_q            <= 1'b0;
    end
    else
    begin
      pwm_q <= pwm;
      on_cnt_q  <= pwm ? (rise_edge ? {CW{1'b0}} : inc(on_cnt_q)) : on_cnt_q;
      off_cnt_q <= pwm ? off_cnt_q : (fall_edge ? {CW{1'b0}} : inc(off_cnt_q));
      if (fall_edge)
        short_q <= on_cnt_q < freewheel_crossconduction_time;
      else if (rise_edge)
        short_q <= off_cnt_q < active_crossconduction_time;
      active_is_high <= active_fw_detect_enable ? detected_high_active :
                        (bridge_drive_mode == `MODE_HIGH_PWM);
      case (bridge_drive_mode)
        `MODE_PASSIVE_OFF:
        begin
          high_side_gate   <= 1'b0;
          low_side_gate    <= 1'b0;
          active_discharge <= 1'b0;
        end
        `MODE_ACTIVE_OFF:
        begin
          high_side_gate   <= 1'b0;
          low_side_gate    <= 1'b0;
          active_discharge <= 1'b1;
        end
        default:
        begin
          active_discharge <= 1'b0;
          if (!follow)
          begin
            high_side_gate <= 1'b0;
            low_side_gate  <= 1'b0;
          end
          else if (bridge_drive_mode == `MODE_LOW_PWM)
          begin
            high_side_gate <= (active_freewheel_sel && !short_q) ? ~pwm : 1'b0;
            low_side_gate  <= pwm;
          end
          else
          begin
            high_side_gate <= pwm;
            low_side_gate  <= (active_freewheel_sel && !short_q) ? ~pwm : 1'b0;
          end
        end
      endcase
      if (follow && (rise_edge || fall_edge))
      begin
        phase    <= `PHASE_PRE_FIRST;
        ph_cnt_q <= {CW{1'b0}};
      end
      else if (phase != `PHASE_NONE)
      begin
        ph_cnt_q <= inc(ph_cnt_q);
        if (ph_cnt_q >= precharge_phase_time)
          phase <= `PHASE_NONE;
        else if (split_precharge_enable && ph_cnt_q >= precharge_split_time)
          phase <= `PHASE_PRE_SECOND;
      end
      phase_current <= (phase == `PHASE_NONE) ? 6'h00 : clamp(cur_sel, max_drive_current_setting);
      if (rise_edge)
      begin
        rise_run_q <= 1'b1;
        rise_cnt_q <= {CW{1'b0}};
      end
      else if (rise_run_q)
      begin
        rise_cnt_q <= inc(rise_cnt_q);
        if (rise_done || rise_cnt_q >= active_blank_time)
        begin
          rise_run_q <= 1'b0;
          measured_switch_times[15:0] <= (rise_done && !short_q) ?
            {{(16-CW){1'b0}}, rise_cnt_q} : 16'h0000;
        end
      end
      if (fall_edge)
      begin
        fall_run_q <= 1'b1;
        fall_cnt_q <= {CW{1'b0}};
      end
      else if (fall_run_q)
      begin
        fall_cnt_q <= inc(fall_cnt_q);
        if (fall_done || fall_cnt_q >= active_crossconduction_time)
        begin
          fall_run_q <= 1'b0;
          measured_switch_times[31:16] <= (fall_done && !short_q) ?
            {{(16-CW){1'b0}}, fall_cnt_q} : 16'h0000;
        end
      end
    end
  end
endmodule

// >>> design/half_bridge_pwm_ctrl.v
`timescale 1ns/10ps
`include "hb_pwm_map.vh"
// Operation
// - inputs one, three, five drive bridges when three inputs selected
// - mode 00 passive off both gates
// - mode 01 pwm drives low side
// - mode 10 pwm drives high side
// - mode 11 active off both gates
// - no split: one precharge current
// - split: two precharge intervals
// - short pulse: pwm mosfet is active
// - short pulse: opposite mosfet stays off
// - measure pwm or detected active mosfet
// - rise timeout reports zero
// - fall timeout reports zero
// - short pulses: short on zeroes fall time, short off zeroes rise time
// - currents clamped to maximum setting
// - pwm inputs synchronized first
module half_bridge_pwm_ctrl #(
  parameter CW = `CNT_W
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          pwm_input_one,
  input  wire          pwm_input_three,
  input  wire          pwm_input_five,
  input  wire          pwm_input_count_sel,
  input  wire [5:0]    bridge_mode_register,
  input  wire [2:0]    bridge_pwm_follow_enable,
  input  wire [2:0]    active_freewheel_sel,
  input  wire          split_precharge_enable,
  input  wire          active_fw_detect_enable,
  input  wire [2:0]    detected_high_active,
  input  wire [CW-1:0] freewheel_crossconduction_time,
  input  wire [CW-1:0] active_crossconduction_time,
  input  wire [CW-1:0] active_blank_time,
  input  wire [CW-1:0] precharge_phase_time,
  input  wire [CW-1:0] precharge_split_time,
  input  wire [5:0]    precharge_current_a,
  input  wire [5:0]    precharge_current_b,
  input  wire [17:0]   max_drive_current_setting,
  input  wire [2:0]    rise_done,
  input  wire [2:0]    fall_done,
  output wire [2:0]    high_side_gate,
  output wire [2:0]    low_side_gate,
  output wire [2:0]    active_discharge,
  output wire [5:0]    precharge_phase,
  output wire [17:0]   precharge_current,
  output wire [2:0]    active_is_high,
  output wire [31:0]   bridge1_measured_switch_times,
  output wire [31:0]   bridge2_measured_switch_times,
  output wire [31:0]   bridge3_measured_switch_times
);
  reg  [2:0] sync1_q;
  reg  [2:0] sync2_q;
  wire [2:0] pwm_int;
  wire [95:0] times;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {pwm_input_five, pwm_input_three, pwm_input_one};
      sync2_q <= sync1_q;
    end
  end

  assign pwm_int = (pwm_input_count_sel == `SEL_THREE_INPUTS) ? sync2_q : 3'h0;

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_br
      bridge_channel #(.CW(CW)) u_ch (
        .clk                            (clk),
        .rst_n                          (rst_n),
        .pwm                            (pwm_int[i]),
        .bridge_drive_mode              (bridge_mode_register[2*i+1:2*i]),
        .bridge_pwm_follow_enable       (bridge_pwm_follow_enable[i]),
        .active_freewheel_sel           (active_freewheel_sel[i]),
        .split_precharge_enable         (split_precharge_enable),
        .active_fw_detect_enable        (active_fw_detect_enable),
        .detected_high_active           (detected_high_active[i]),
        .freewheel_crossconduction_time (freewheel_crossconduction_time),
        .active_crossconduction_time    (active_crossconduction_time),
        .active_blank_time              (active_blank_time),
        .precharge_phase_time           (precharge_phase_time),
        .precharge_split_time           (precharge_split_time),
        .precharge_current_a            (precharge_current_a),
        .precharge_current_b            (precharge_current_b),
        .max_drive_current_setting      (max_drive_current_setting[6*i+5:6*i]),
        .rise_done                      (rise_done[i]),
        .fall_done                      (fall_done[i]),
        .high_side_gate                 (high_side_gate[i]),
        .low_side_gate                  (low_side_gate[i]),
        .active_discharge               (active_discharge[i]),
        .phase                          (precharge_phase[2*i+1:2*i]),
        .phase_current                  (precharge_current[6*i+5:6*i]),
        .active_is_high                 (active_is_high[i]),
        .measured_switch_times          (times[32*i+31:32*i])
      );
    end
  endgenerate

  assign bridge1_measured_switch_times = times[31:0];
  assign bridge2_measured_switch_times = times[63:32];
  assign bridge3_measured_switch_times = times[95:64];
endmodule

// >>> design/hb_pwm_map.vh
`ifndef HB_PWM_MAP_VH
`define HB_PWM_MAP_VH
`define MODE_PASSIVE_OFF   2'h0
`define MODE_LOW_PWM       2'h1
`define MODE_HIGH_PWM      2'h2
`define MODE_ACTIVE_OFF    2'h3
`define SEL_THREE_INPUTS   1'h0
`define PHASE_NONE         2'h0
`define PHASE_PRE_FIRST    2'h1
`define PHASE_PRE_SECOND   2'h2
`define CNT_W              8
`define RST_CNT            8'h00
`define RST_TIMES          32'h0000_0000
`define SYNC_STAGES        2
`endif

// >>> sim/half_bridge_pwm_ctrl_tb.sv
`timescale 1ns/10ps
module half_bridge_pwm_ctrl_tb;
  logic        clk = 0, rst_n = 0, sel = 0, split = 0, det_en = 0, go = 0;
  logic        sense = 0, g1 = 0, g2 = 0;
  logic [5:0]  mode = 6'h00, ph;
  logic [2:0]  en = 3'h7, afw = 3'h0, mask = 3'h7, det_hi = 3'h7;
  logic [7:0]  t = 8'h0A, lo = 8'h1E, ccp_fw = 8'h0A, ccp_act = 8'h0A, blank = 8'h0A;
  logic [17:0] cur_max = 18'h071C7;
  logic [2:0]  pwm, hs, ls, ah;
  logic        busy;
  logic [31:0] tm, tm2, tm3;
  int          errors = 0, n_checks = 0, n2 = 0, c2 = 0;
  always #2.5 clk = ~clk;
  pwm_source far (.clk, .rst_n, .go, .hi(t), .lo(lo), .mask, .pwm, .busy);
  half_bridge_pwm_ctrl dut (.clk, .rst_n, .pwm_input_one(pwm[0]), .pwm_input_three(pwm[1]),
    .pwm_input_five(pwm[2]), .pwm_input_count_sel(sel), .bridge_mode_register(mode),
    .bridge_pwm_follow_enable(en), .active_freewheel_sel(afw), .split_precharge_enable(split),
    .active_fw_detect_enable(det_en), .detected_high_active(det_hi),
    .freewheel_crossconduction_time(ccp_fw), .active_crossconduction_time(ccp_act),
    .active_blank_time(blank), .precharge_phase_time(8'h08), .precharge_split_time(8'h03),
    .precharge_current_a(6'h05), .precharge_current_b(6'h09),
    .max_drive_current_setting(cur_max), .rise_done({2'h0, sense & g2}),
    .fall_done({2'h0, sense & ~g2}), .high_side_gate(hs), .low_side_gate(ls),
    .active_discharge(), .precharge_phase(ph), .precharge_current(), .active_is_high(ah),
    .bridge1_measured_switch_times(tm), .bridge2_measured_switch_times(tm2),
    .bridge3_measured_switch_times(tm3));
  // gate sensing seen two cycles late
  always @(posedge clk)
  begin
    g1 <= hs[0];
    g2 <= g1;
    if (ph[1:0] === 2'h2)
      n2 <= n2 + 1;
  end
  task chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test;
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task pulse(input logic [7:0] hi, input int at, input logic [2:0] eh, el);
    int n;
    t <= hi;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (at) @(posedge clk);
    #1;
    chk("high gates", hs, eh);
    chk("low gates", ls, el);
    for (n = 0; n < 600 && busy; n++)
      @(posedge clk);
    if (busy)
    begin
      errors++;
      end_of_test;
    end
    repeat (20) @(posedge clk);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      mode <= {3{i[2:1]}};
      afw <= {3{i[2:1] == 2'h2}};
      @(posedge clk);
      pulse(8'h1E, i[0] ? 40 : 10, {3{!i[0] && i[2:1] == 2'h2}},
        {3{i[0] ? i[2:1] == 2'h2 : i[2:1] == 2'h1}});
    end
    mode <= 6'h2A;
    afw <= 3'h7;
    mask <= 3'h2;
    pulse(8'h1E, 10, 3'h2, 3'h5);
    mask <= 3'h7;
    sel <= 1'b1;
    pulse(8'h1E, 10, 3'h0, 3'h7);
    sel <= 1'b0;
    en <= 3'h0;
    pulse(8'h1E, 10, 3'h0, 3'h0);
    en <= 3'h7;
    c2 = n2;
    pulse(8'h1E, 10, 3'h7, 3'h0);
    chk("second interval", n2 != c2, 1'b0);
    split <= 1'b1;
    c2 = n2;
    pulse(8'h1E, 10, 3'h7, 3'h0);
    chk("second interval", n2 != c2, 1'b1);
    sense <= 1'b1;
    det_en <= 1'b1;
    det_hi <= 3'h5;
    pulse(8'h1E, 10, 3'h7, 3'h0);
    chk("rise measured", tm[15:0] != 16'h0000, 1'b1);
    chk("fall measured", tm[31:16] != 16'h0000, 1'b1);
    chk("measured side", ah, 3'h5);
    sense <= 1'b0;
    pulse(8'h1E, 10, 3'h7, 3'h0);
    chk("timed out times", tm, 32'h0);
    chk("other bridge times", tm2 | tm3, 32'h0);
    sense <= 1'b1;
    pulse(8'h03, 10, 3'h0, 3'h0);
    pulse(8'h03, 10, 3'h0, 3'h0);
    // short on and short off burst
    lo <= 8'h03;
    go <= 1'b1;
    repeat (60) @(posedge clk);
    go <= 1'b0;
    #1;
    chk("short burst low gates", ls, 3'h0);
    repeat (40) @(posedge clk);
    chk("short pulse times", tm, 32'h0);
    end_of_test;
  end
endmodule

// >>> sim/hb_ctrl_sva.sv
`timescale 1ns/10ps
module hb_ctrl_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        pwm_input_one,
  input wire logic        pwm_input_three,
  input wire logic        pwm_input_count_sel,
  input wire logic [5:0]  bridge_mode_register,
  input wire logic [2:0]  bridge_pwm_follow_enable,
  input wire logic [2:0]  active_freewheel_sel,
  input wire logic        split_precharge_enable,
  input wire logic [17:0] max_drive_current_setting,
  input wire logic [2:0]  high_side_gate,
  input wire logic [2:0]  low_side_gate,
  input wire logic [2:0]  active_discharge,
  input wire logic [5:0]  precharge_phase,
  input wire logic [17:0] precharge_current
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire [1:0] m1  = bridge_mode_register[1:0];
  wire [1:0] m2  = bridge_mode_register[3:2];
  wire       f1  = bridge_pwm_follow_enable[0] && !pwm_input_count_sel;
  wire       off = !high_side_gate[0] && !low_side_gate[0];
  passive_off_a: assert property (m1 == 2'h0 |=> off)
    else $error("bridge one not off in passive mode");
  active_off_a: assert property (m1 == 2'h3 |=> off && active_discharge[0])
    else $error("bridge one not actively off");
  follow_off_a: assert property (m1[1] != m1[0] && !bridge_pwm_follow_enable[0] |=> off)
    else $error("bridge one follows while disabled");
  high_follow_a: assert property ((m1 == 2'h2 && f1 && active_freewheel_sel[0]) [*3]
    |=> high_side_gate[0] == $past(pwm_input_one, 3))
    else $error("high gate does not follow input");
  low_follow_a: assert property ((m1 == 2'h1 && f1 && !active_freewheel_sel[0]) [*3]
    |=> low_side_gate[0] == $past(pwm_input_one, 3) && !high_side_gate[0])
    else $error("low gate does not follow input");
  input_map_a: assert property ((m2 == 2'h2 && bridge_pwm_follow_enable[1] &&
    active_freewheel_sel[1] && !pwm_input_count_sel) [*3]
    |=> high_side_gate[1] == $past(pwm_input_three, 3))
    else $error("bridge two not driven by input three");
  current_clamp_a: assert property ($stable(max_drive_current_setting[5:0])
    |-> precharge_current[5:0] <= max_drive_current_setting[5:0])
    else $error("precharge current above maximum");
  split_phase_a: assert property (precharge_phase[1:0] == 2'h2
    |-> $past(split_precharge_enable))
    else $error("second interval without split");
endmodule
bind half_bridge_pwm_ctrl hb_ctrl_sva chk (.clk, .rst_n, .pwm_input_one, .pwm_input_three,
  .pwm_input_count_sel, .bridge_mode_register, .bridge_pwm_follow_enable,
  .active_freewheel_sel, .split_precharge_enable, .max_drive_current_setting,
  .high_side_gate, .low_side_gate, .active_discharge, .precharge_phase, .precharge_current);

// >>> sim/pwm_source.sv
`timescale 1ns/10ps
module pwm_source (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [7:0] hi,
  input  wire logic [7:0] lo,
  input  wire logic [2:0] mask,
  output wire logic [2:0] pwm,
  output wire logic       busy
);
  logic [8:0] cnt_q;
  // one high then one low stretch per request
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      cnt_q <= 9'h000;
    else if (go && cnt_q == 9'h000)
      cnt_q <= {1'b0, hi} + {1'b0, lo};
    else if (cnt_q != 9'h000)
      cnt_q <= cnt_q - 9'h001;
  assign busy = cnt_q != 9'h000;
  assign pwm  = (cnt_q > {1'b0, lo}) ? mask : 3'h0;
endmodule
